// ### clsr_host_regs.sv
// Host register bank of a two-channel camera link simulator: command,
// status, configuration, control-line readback, serial UART and flags.
// Assumes synchronous inputs, one clock, one-cycle read/write strobes.
`timescale 1ns/100ps

module clsr_host_regs
#(
  parameter int NCH = 2
)
(
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic [7:0]     addr,
  input  wire logic [7:0]     wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output logic      [7:0]     rdata,
  input  wire logic [NCH-1:0] fifo_has_data,
  input  wire logic [NCH-1:0] frame_valid,
  input  wire logic [NCH-1:0] fifo_underrun,
  input  wire logic [3:0]     cc_lines [NCH],
  input  wire logic [NCH-1:0] ser_from_grabber,
  output logic      [NCH-1:0] ser_to_grabber,
  output logic      [NCH-1:0] sim_clear,
  output logic      [NCH-1:0] summary_irq
);

  initial
  begin
    if (NCH < 1 || NCH > 2)
      $error("clsr_host_regs: NCH must be 1 or 2");
  end

  typedef struct packed {
    logic [7:0]               cfg;
    logic [7:0]               util2;
    logic [7:0]               sctl;
    logic [7:0]               baud;
    logic                     fv_prev;
    logic                     frame_edge_latched;
    logic [7:0]               tx_hold;
    logic                     tx_full;
    logic [7:0]               tx_shift;
    clsr_pkg::clsr_uart_st_t  tx_st;
    logic [2:0]               tx_bit;
    logic [clsr_pkg::DIV_W-1:0] tx_cnt;
    logic                     tx_line;
    logic [1:0]               rx_sync;
    logic [7:0]               rx_shift;
    clsr_pkg::clsr_uart_st_t  rx_st;
    logic [2:0]               rx_bit;
    logic [clsr_pkg::DIV_W-1:0] rx_cnt;
    logic [7:0]               rx_data;
    logic                     rx_ready;
  } clsr_ch_t;

  typedef struct packed {
    clsr_ch_t [NCH-1:0] ch;
    logic [7:0]         rdata;
  } clsr_state_t;

  clsr_state_t st_r;
  clsr_state_t st_nxt;

  // Bit period in clocks from the rate select or programmed divisor
  function automatic logic [clsr_pkg::DIV_W-1:0] bit_period(
    input logic [7:0] baud,
    input logic [1:0] sel);
    logic [31:0] p;
    p = 32'h0;
    if (baud != 8'h00)
      p = 32'((clsr_pkg::CLK_HZ / clsr_pkg::REF_HZ)
              * clsr_pkg::REF_TICKS_PER_BIT
              * (32'(baud) + 32'(clsr_pkg::PROG_OFFSET)));
    else
    begin
      case (sel)
        2'h0: p = 32'(clsr_pkg::DIV_9600);
        2'h1: p = 32'(clsr_pkg::DIV_19200);
        2'h2: p = 32'(clsr_pkg::DIV_38400);
        default: p = 32'(clsr_pkg::DIV_115200);
      endcase
    end
    return p[clsr_pkg::DIV_W-1:0];
  endfunction

  function automatic logic [7:0] sstat_of(input clsr_ch_t c);
    logic [7:0] s;
    logic       qual;
    s = 8'h00;
    qual = c.frame_edge_latched & c.util2[clsr_pkg::UTIL2_FVEN_BIT];
    s[clsr_pkg::SS_EDGE_BIT]  = c.frame_edge_latched;
    s[clsr_pkg::SS_QUAL_BIT]  = qual;
    s[clsr_pkg::SS_TXRDY_BIT] = ~c.tx_full;
    s[clsr_pkg::SS_RXRDY_BIT] = c.rx_ready;
    s[clsr_pkg::SS_SUM_BIT] = c.sctl[clsr_pkg::SC_GIE_BIT] &
      (qual
       | (~c.tx_full & c.sctl[clsr_pkg::SC_TXIE_BIT])
       | (c.rx_ready & c.sctl[clsr_pkg::SC_RXIE_BIT]));
    return s;
  endfunction

  always_comb
  begin
    logic                       sel_ch;
    logic [6:0]                 a;
    logic                       wr_hit;
    logic [clsr_pkg::DIV_W-1:0] per;
    clsr_ch_t                   c;
    wr_hit = 1'b0;
    per    = '0;
    c      = '0;
    st_nxt = st_r;
    sel_ch = addr[7];
    a      = addr[6:0];
    st_nxt.rdata = 8'h00;
    for (int i = 0; i < NCH; i++)
    begin
      c = st_r.ch[i];
      wr_hit = wr && (sel_ch == 1'(i));
      per = bit_period(c.baud, c.sctl[7:6]);
      if (wr_hit)
      begin
        case (a)
          clsr_pkg::ADDR_CFG:   c.cfg   = wdata;
          clsr_pkg::ADDR_UTIL2: c.util2 = wdata;
          clsr_pkg::ADDR_BAUD:  c.baud  = wdata;
          clsr_pkg::ADDR_SCTL:  c.sctl  = wdata;
          default: ;
        endcase
      end
      // Clears come first so a coincident rising edge still sets the flag
      if (wr_hit && a == clsr_pkg::ADDR_CMD &&
          (wdata[clsr_pkg::CMD_CLR_BIT] | wdata[clsr_pkg::CMD_RST_BIT]))
        c.frame_edge_latched = 1'b0;
      c.fv_prev = frame_valid[i];
      if (frame_valid[i] && !st_r.ch[i].fv_prev)
        c.frame_edge_latched = 1'b1;
      // Host write to the data port loads the holding register
      if (wr_hit && a == clsr_pkg::ADDR_SDATA && !c.tx_full)
      begin
        c.tx_hold = wdata;
        c.tx_full = 1'b1;
      end
      // Transmitter: start, 8 data LSB first, stop
      case (c.tx_st)
        clsr_pkg::UART_IDLE:
        begin
          c.tx_line = 1'b1;
          if (c.tx_full && c.sctl[clsr_pkg::SC_TXEN_BIT])
          begin
            c.tx_shift = c.tx_hold;
            c.tx_full  = 1'b0;
            c.tx_st    = clsr_pkg::UART_START;
            c.tx_cnt   = per;
            c.tx_line  = 1'b0;
          end
        end
        clsr_pkg::UART_START, clsr_pkg::UART_DATA, clsr_pkg::UART_STOP:
        begin
          if (c.tx_cnt > 1)
            c.tx_cnt = c.tx_cnt - 1'b1;
          else
          begin
            c.tx_cnt = per;
            if (c.tx_st == clsr_pkg::UART_START)
            begin
              c.tx_st   = clsr_pkg::UART_DATA;
              c.tx_bit  = 3'h0;
              c.tx_line = c.tx_shift[0];
            end
            else if (c.tx_st == clsr_pkg::UART_DATA)
            begin
              if (c.tx_bit == 3'h7)
              begin
                c.tx_st   = clsr_pkg::UART_STOP;
                c.tx_line = 1'b1;
              end
              else
              begin
                c.tx_bit   = c.tx_bit + 1'b1;
                c.tx_shift = {1'b0, c.tx_shift[7:1]};
                c.tx_line  = c.tx_shift[0];
              end
            end
            else
              c.tx_st = clsr_pkg::UART_IDLE;
          end
        end
        default: c.tx_st = clsr_pkg::UART_IDLE;
      endcase
      // Dropping the enable aborts a frame; the line returns to idle at once
      if (!c.sctl[clsr_pkg::SC_TXEN_BIT] && c.tx_st != clsr_pkg::UART_IDLE)
      begin
        c.tx_st   = clsr_pkg::UART_IDLE;
        c.tx_line = 1'b1;
      end
      // Receiver samples mid-bit; a missing stop bit drops the byte
      c.rx_sync = {st_r.ch[i].rx_sync[0], ser_from_grabber[i]};
      if (wr_hit && a == clsr_pkg::ADDR_SCTL &&
          wdata[clsr_pkg::SC_RXCLR_BIT])
        c.rx_ready = 1'b0;
      case (c.rx_st)
        clsr_pkg::UART_IDLE:
        begin
          if (c.sctl[clsr_pkg::SC_RXEN_BIT] && !st_r.ch[i].rx_sync[1])
          begin
            c.rx_st  = clsr_pkg::UART_START;
            c.rx_cnt = {1'b0, per[clsr_pkg::DIV_W-1:1]};
          end
        end
        clsr_pkg::UART_START, clsr_pkg::UART_DATA, clsr_pkg::UART_STOP:
        begin
          if (c.rx_cnt > 1)
            c.rx_cnt = c.rx_cnt - 1'b1;
          else
          begin
            c.rx_cnt = per;
            if (c.rx_st == clsr_pkg::UART_START)
            begin
              c.rx_bit = 3'h0;
              c.rx_st  = st_r.ch[i].rx_sync[1] ? clsr_pkg::UART_IDLE
                                               : clsr_pkg::UART_DATA;
            end
            else if (c.rx_st == clsr_pkg::UART_DATA)
            begin
              c.rx_shift = {st_r.ch[i].rx_sync[1], c.rx_shift[7:1]};
              if (c.rx_bit == 3'h7)
                c.rx_st = clsr_pkg::UART_STOP;
              else
                c.rx_bit = c.rx_bit + 1'b1;
            end
            else
            begin
              if (st_r.ch[i].rx_sync[1])
              begin
                c.rx_data  = c.rx_shift;
                c.rx_ready = 1'b1;
              end
              c.rx_st = clsr_pkg::UART_IDLE;
            end
          end
        end
        default: c.rx_st = clsr_pkg::UART_IDLE;
      endcase
      if (!c.sctl[clsr_pkg::SC_RXEN_BIT] && c.rx_st != clsr_pkg::UART_IDLE)
        c.rx_st = clsr_pkg::UART_IDLE;
      // Reading the data port consumes the received byte
      if (rd && sel_ch == 1'(i) && a == clsr_pkg::ADDR_SDATA)
        c.rx_ready = 1'b0;
      // Simulator clear holds flags and UART idle while set
      if (c.cfg[clsr_pkg::CFG_CLEAR_BIT])
      begin
        c.frame_edge_latched = 1'b0;
        c.tx_full  = 1'b0;
        c.tx_st    = clsr_pkg::UART_IDLE;
        c.tx_line  = 1'b1;
        c.rx_st    = clsr_pkg::UART_IDLE;
        c.rx_ready = 1'b0;
      end
      st_nxt.ch[i] = c;
      if (rd && sel_ch == 1'(i))
      begin
        case (a)
          clsr_pkg::ADDR_CMD:    st_nxt.rdata = clsr_pkg::CMD_READ_VALUE;
          clsr_pkg::ADDR_STAT:
          begin
            st_nxt.rdata[clsr_pkg::STAT_FIFO_BIT] = fifo_has_data[i];
            st_nxt.rdata[clsr_pkg::STAT_FV_BIT]   = frame_valid[i];
            st_nxt.rdata[clsr_pkg::STAT_UNDR_BIT] = fifo_underrun[i];
          end
          clsr_pkg::ADDR_CFG:    st_nxt.rdata = st_r.ch[i].cfg;
          clsr_pkg::ADDR_CCREAD: st_nxt.rdata = {4'h0, cc_lines[i]};
          clsr_pkg::ADDR_SDATA:  st_nxt.rdata = st_r.ch[i].rx_data;
          clsr_pkg::ADDR_SSTAT:  st_nxt.rdata = sstat_of(st_r.ch[i]);
          clsr_pkg::ADDR_SCTL:   st_nxt.rdata = st_r.ch[i].sctl;
          clsr_pkg::ADDR_UTIL2:  st_nxt.rdata = st_r.ch[i].util2;
          clsr_pkg::ADDR_BAUD:   st_nxt.rdata = st_r.ch[i].baud;
          default:               st_nxt.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        st_r.ch[i].tx_st   <= clsr_pkg::UART_IDLE;
        st_r.ch[i].rx_st   <= clsr_pkg::UART_IDLE;
        st_r.ch[i].tx_line <= 1'b1;
        st_r.ch[i].rx_sync <= 2'h3;
      end
    end
    else
      st_r <= st_nxt;
  end

  always_comb
  begin
    logic [7:0] ss;
    ss    = 8'h00;
    rdata = st_r.rdata;
    for (int i = 0; i < NCH; i++)
    begin
      ser_to_grabber[i] = st_r.ch[i].tx_line;
      sim_clear[i]      = st_r.ch[i].cfg[clsr_pkg::CFG_CLEAR_BIT];
      ss                = sstat_of(st_r.ch[i]);
      summary_irq[i]    = ss[clsr_pkg::SS_SUM_BIT];
    end
  end

endmodule

// ### clsr_pkg.sv
// Constants for the two-channel camera link simulator host register block.
// Assumes an 8-bit register port and a 125 MHz system clock.
package clsr_pkg;

  localparam logic [7:0] CH1_OFFSET     = 8'h80;
  localparam logic [6:0] ADDR_CMD       = 7'h00;
  localparam logic [6:0] ADDR_STAT      = 7'h01;
  localparam logic [6:0] ADDR_CFG       = 7'h02;
  localparam logic [6:0] ADDR_RSVD      = 7'h05;
  localparam logic [6:0] ADDR_CCREAD    = 7'h07;
  localparam logic [6:0] ADDR_SDATA     = 7'h0a;
  localparam logic [6:0] ADDR_SSTAT     = 7'h0b;
  localparam logic [6:0] ADDR_SCTL      = 7'h0c;
  localparam logic [6:0] ADDR_UTIL2     = 7'h10;
  localparam logic [6:0] ADDR_BAUD      = 7'h24;

  localparam logic [7:0] CMD_READ_VALUE = 8'h02;
  localparam int         CMD_CLR_BIT    = 4;
  localparam int         CMD_RST_BIT    = 0;
  localparam int         STAT_FIFO_BIT  = 4;
  localparam int         STAT_FV_BIT    = 1;
  localparam int         STAT_UNDR_BIT  = 0;
  localparam int         CFG_CLEAR_BIT  = 3;
  localparam int         UTIL2_FVEN_BIT = 3;
  localparam int         SS_SUM_BIT     = 7;
  localparam int         SS_EDGE_BIT    = 6;
  localparam int         SS_QUAL_BIT    = 4;
  localparam int         SS_TXRDY_BIT   = 1;
  localparam int         SS_RXRDY_BIT   = 0;
  localparam int         SC_RXCLR_BIT   = 5;
  localparam int         SC_GIE_BIT     = 4;
  localparam int         SC_TXIE_BIT    = 3;
  localparam int         SC_RXIE_BIT    = 2;
  localparam int         SC_TXEN_BIT    = 1;
  localparam int         SC_RXEN_BIT    = 0;

  localparam int CLK_HZ      = 125000000;
  localparam int REF_HZ      = 20000000;
  // Fixed rate table: baud rates, then their divisors in system clocks per bit
  localparam int BAUD_9600   = 9600;
  localparam int BAUD_19200  = 19200;
  localparam int BAUD_38400  = 38400;
  localparam int BAUD_115200 = 115200;
  localparam int DIV_W       = 16;
  localparam logic [DIV_W-1:0] DIV_9600   = DIV_W'(CLK_HZ / BAUD_9600);
  localparam logic [DIV_W-1:0] DIV_19200  = DIV_W'(CLK_HZ / BAUD_19200);
  localparam logic [DIV_W-1:0] DIV_38400  = DIV_W'(CLK_HZ / BAUD_38400);
  localparam logic [DIV_W-1:0] DIV_115200 = DIV_W'(CLK_HZ / BAUD_115200);
  // Programmed rate: 16 ref ticks per bit at (value+2); scaled to clk
  localparam int REF_TICKS_PER_BIT = 16;
  localparam int PROG_OFFSET       = 2;

  typedef enum logic [3:0]
  {
    UART_IDLE  = 4'h1,
    UART_START = 4'h2,
    UART_DATA  = 4'h4,
    UART_STOP  = 4'h8
  } clsr_uart_st_t;

endpackage

// ### clsr_grabber_model.sv
// Frame grabber end of the serial link: 8N1 receiver and sender.
// Assumes the bench sets the bit period in system clocks.
`timescale 1ns/100ps
module clsr_grabber_model
(
  input  wire logic        clk,
  input  wire logic        ser_in,
  output logic             ser_out,
  input  wire logic [15:0] period
);
  logic [7:0] rx_q [$];
  logic [7:0] b;
  initial ser_out = 1'b1;
  // Samples mid-bit, LSB first; bad stop bit drops the byte
  initial
  begin
    forever
    begin
      @(negedge ser_in);
      repeat (period / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (period) @(posedge clk);
        b[i] = ser_in;
      end
      repeat (period) @(posedge clk);
      if (ser_in === 1'b1)
        rx_q.push_back(b);
    end
  end
  task send_byte(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      ser_out <= f[i];
      repeat (period - 1) @(posedge clk);
    end
  endtask
endmodule

// ### clsr_host_regs_asserts.sv
// Checker of the host register bank, bound to its top ports.
// Assumes one-cycle strobes and registered read data.
`timescale 1ns/100ps
module clsr_host_regs_chk
#(
  parameter int NCH = 2
)
(
  input wire logic           clk,
  input wire logic           rstn,
  input wire logic [7:0]     addr,
  input wire logic [7:0]     wdata,
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [7:0]     rdata,
  input wire logic [NCH-1:0] fifo_has_data,
  input wire logic [NCH-1:0] frame_valid,
  input wire logic [NCH-1:0] fifo_underrun,
  input wire logic [3:0]     cc_lines [NCH],
  input wire logic [NCH-1:0] ser_from_grabber,
  input wire logic [NCH-1:0] ser_to_grabber,
  input wire logic [NCH-1:0] sim_clear,
  input wire logic [NCH-1:0] summary_irq
);
  logic [7:0]     sctl_r [NCH];
  logic [NCH-1:0] fven_r;
  logic [NCH-1:0] gie;
  logic [NCH-1:0] txen;
  logic [7:0]     sc_sel;
  logic [7:0]     st_sel;
  logic [3:0]     cc_sel;
  logic           ch;
  logic [6:0]     off;
  assign ch  = addr[7];
  assign off = addr[6:0];
  // Shadow of the enables, updated on the same edge as the bank
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sctl_r <= '{default: 8'h00};
      fven_r <= '0;
    end
    else if (wr)
    begin
      if (off == clsr_pkg::ADDR_SCTL)
        sctl_r[ch] <= wdata;
      if (off == clsr_pkg::ADDR_UTIL2)
        fven_r[ch] <= wdata[3];
    end
  end
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      gie[i]  = sctl_r[i][4];
      txen[i] = sctl_r[i][1];
    end
    sc_sel = sctl_r[ch];
    st_sel = {3'h0, fifo_has_data[ch], 2'h0, frame_valid[ch],
              fifo_underrun[ch]};
    cc_sel = cc_lines[ch];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  cmd_read_a: assert property (rd && off == clsr_pkg::ADDR_CMD
    |=> rdata == clsr_pkg::CMD_READ_VALUE) else $error("cmd read");
  rsvd_read_a: assert property (rd && off == clsr_pkg::ADDR_RSVD
    |=> rdata == 8'h00) else $error("reserved read");
  cc_read_a: assert property (rd && off == clsr_pkg::ADDR_CCREAD
    |=> rdata == {4'h0, $past(cc_sel)}) else $error("cc read");
  status_read_a: assert property (rd && off == clsr_pkg::ADDR_STAT
    |=> rdata == $past(st_sel)) else $error("status read");
  clear_level_a: assert property (wr && off == clsr_pkg::ADDR_CFG
    |=> sim_clear[$past(ch)] == $past(wdata[3])) else $error("clear");
  gie_gate_a: assert property ((summary_irq & ~gie) == '0)
    else $error("irq without enable");
  tx_idle_a: assert property ((ser_to_grabber | txen) == '1)
    else $error("tx not idle");
  qual_flag_a: assert property (rd && off == clsr_pkg::ADDR_SSTAT
    |=> rdata[4] == (rdata[6] & $past(fven_r[ch]))) else $error("qual");
  sum_flag_a: assert property (rd && off == clsr_pkg::ADDR_SSTAT
    |=> rdata[7] == ($past(sc_sel[4]) & (rdata[4] | rdata[1] &
    $past(sc_sel[3]) | rdata[0] & $past(sc_sel[2])))) else $error("sum");
endmodule
bind clsr_host_regs clsr_host_regs_chk #(.NCH(NCH)) u_chk (.clk(clk),
  .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .fifo_has_data(fifo_has_data), .frame_valid(frame_valid),
  .fifo_underrun(fifo_underrun), .cc_lines(cc_lines),
  .ser_from_grabber(ser_from_grabber), .ser_to_grabber(ser_to_grabber),
  .sim_clear(sim_clear), .summary_irq(summary_irq));

// ### clsr_host_regs_bench.sv
// Self-checking bench of the host register bank with a grabber model.
// Assumes a 125 MHz clock; the model listens on channel 0 only.
`timescale 1ns/100ps
module clsr_host_regs_bench;
  logic        clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [1:0]  fh;
  logic [1:0]  fv;
  logic [1:0]  fu;
  logic [3:0]  cc [2];
  logic [1:0]  ser_to;
  logic [1:0]  clr;
  logic [1:0]  irq;
  logic        grab_tx;
  logic [15:0] per;
  logic [7:0]  v;
  logic [7:0]  d;
  logic [6:0]  rw_offs [4];
  int          n_errors;
  int          comparisons;
  int          cyc;
  int          seed;
  int          img [256];
  clsr_host_regs #(.NCH(2)) dut (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fifo_has_data(fh),
    .frame_valid(fv), .fifo_underrun(fu), .cc_lines(cc),
    .ser_from_grabber({1'b1, grab_tx}), .ser_to_grabber(ser_to),
    .sim_clear(clr), .summary_irq(irq));
  clsr_grabber_model grab (.clk(clk), .ser_in(ser_to[0]),
    .ser_out(grab_tx), .period(per));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  function logic [7:0] ad(input int c, input logic [6:0] o);
    return {c[0], o};
  endfunction
  // Unused bits of CFG and UTIL2 written as zero
  function logic [7:0] msk(input logic [7:0] a);
    if (a[6:0] == clsr_pkg::ADDR_CFG || a[6:0] == clsr_pkg::ADDR_UTIL2)
      return 8'h08;
    return 8'hff;
  endfunction
  task wr_reg(input logic [7:0] a, input logic [7:0] x);
    img[a] = x & msk(a);
    @(posedge clk);
    addr  <= a;
    wdata <= x & msk(a);
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  initial
  begin
    {rstn, addr, wdata, wr, rd, fh, fv, fu} = '0;
    cc   = '{4'h0, 4'h0};
    seed = 90;
    per  = 16'd288;
    rw_offs = '{clsr_pkg::ADDR_CFG, clsr_pkg::ADDR_SCTL,
                clsr_pkg::ADDR_UTIL2, clsr_pkg::ADDR_BAUD};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int c = 0; c < 2; c++)
    begin
      rchk("cmd", ad(c, clsr_pkg::ADDR_CMD), clsr_pkg::CMD_READ_VALUE);
      rchk("rsvd", ad(c, clsr_pkg::ADDR_RSVD), 8'h00);
      rchk("sstat", ad(c, clsr_pkg::ADDR_SSTAT), 8'h02);
    end
    $display("reset test done");
    repeat (12)
    begin
      for (int c = 0; c < 2; c++)
        foreach (rw_offs[k])
          wr_reg(ad(c, rw_offs[k]), $random(seed));
      for (int c = 0; c < 2; c++)
      begin
        chk("clear",
            {7'h0, img[ad(c, clsr_pkg::ADDR_CFG)][clsr_pkg::CFG_CLEAR_BIT]},
            {7'h0, clr[c]});
        foreach (rw_offs[k])
          rchk("rw", ad(c, rw_offs[k]), img[ad(c, rw_offs[k])]);
      end
      {fh, fv, fu} <= $random(seed);
      cc <= '{4'($random(seed)), 4'($random(seed))};
      @(posedge clk);
      for (int c = 0; c < 2; c++)
      begin
        rchk("stat", ad(c, clsr_pkg::ADDR_STAT),
             {3'h0, fh[c], 2'h0, fv[c], fu[c]});
        rchk("cc", ad(c, clsr_pkg::ADDR_CCREAD), {4'h0, cc[c]});
      end
    end
    $display("register test done");
    for (int c = 0; c < 2; c++)
    begin
      wr_reg(ad(c, clsr_pkg::ADDR_CFG), 8'h00);
      wr_reg(ad(c, clsr_pkg::ADDR_SCTL), 8'h10);
      wr_reg(ad(c, clsr_pkg::ADDR_UTIL2), 8'h08);
      wr_reg(ad(c, clsr_pkg::ADDR_BAUD), 8'h00);
      fv[c] <= 1'b0;
      wr_reg(ad(c, clsr_pkg::ADDR_CMD), 8'h01);
      rchk("sstat", ad(c, clsr_pkg::ADDR_SSTAT), 8'h02);
      fv[c] <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("sstat", ad(c, clsr_pkg::ADDR_SSTAT), 8'hd2);
      chk("irq", {7'h0, irq[c]}, 8'h01);
      wr_reg(ad(c, clsr_pkg::ADDR_CMD), 8'h10);
      rchk("sstat", ad(c, clsr_pkg::ADDR_SSTAT), 8'h02);
      fv[c] <= 1'b0;
      repeat (3) @(posedge clk);
      fv[c] <= 1'b1;
      wr_reg(ad(c, clsr_pkg::ADDR_UTIL2), 8'h00);
      rchk("sstat", ad(c, clsr_pkg::ADDR_SSTAT), 8'h42);
      wr_reg(ad(c, clsr_pkg::ADDR_CMD), 8'h01);
      rchk("sstat", ad(c, clsr_pkg::ADDR_SSTAT), 8'h02);
      wr_reg(ad(c, clsr_pkg::ADDR_SCTL), 8'h08);
      chk("irq", {7'h0, irq[c]}, 8'h00);
      wr_reg(ad(c, clsr_pkg::ADDR_SCTL), 8'h18);
      rchk("sstat", ad(c, clsr_pkg::ADDR_SSTAT), 8'h82);
      wr_reg(ad(c, clsr_pkg::ADDR_SCTL), 8'h00);
    end
    $display("frame flag test done");
    for (int k = 0; k < 2; k++)
    begin
      // First byte on the programmed divisor, then the fastest table rate
      per = k ? 16'd1085 : 16'd288;
      wr_reg(ad(0, clsr_pkg::ADDR_BAUD), k ? 8'h00 : 8'h01);
      wr_reg(ad(0, clsr_pkg::ADDR_SCTL), k ? 8'hc2 : 8'h02);
      v = $random(seed);
      wr_reg(ad(0, clsr_pkg::ADDR_SDATA), v);
      for (int w = 0; w < 20000 && grab.rx_q.size() == 0; w++)
        @(posedge clk);
      d = grab.rx_q.size() ? grab.rx_q.pop_front() : ~v;
      chk("tx byte", v, d);
    end
    $display("transmit test done");
    per = 16'd288;
    wr_reg(ad(0, clsr_pkg::ADDR_BAUD), 8'h01);
    wr_reg(ad(0, clsr_pkg::ADDR_SCTL), 8'h15);
    v = $random(seed);
    grab.send_byte(v);
    rchk("sstat", ad(0, clsr_pkg::ADDR_SSTAT), 8'h83);
    rchk("rx byte", ad(0, clsr_pkg::ADDR_SDATA), v);
    grab.send_byte(~v);
    wr_reg(ad(0, clsr_pkg::ADDR_SCTL), 8'h35);
    rchk("sstat", ad(0, clsr_pkg::ADDR_SSTAT), 8'h02);
    $display("receive test done");
    end_of_test();
  end
endmodule
